// ===== rtl/usbc_pkg.sv
/*
  Shared constants and types for the serial port bit clock, pin and frame logic.
  Assumes a single system clock; some field codes here are used by more than one file.
*/
package usbc_pkg;
  // ==========================================================
  // clock source and divider
  localparam logic [1:0] CLK_SRC_MAIN = 2'h0;
  localparam logic [1:0] CLK_SRC_DIV = 2'h1;
  localparam logic [1:0] CLK_SRC_EXT = 2'h3;
  localparam logic [1:0] CLK_SRC_RESET = 2'h0;
  localparam int PREDIV_RATIO = 8;
  localparam logic [2:0] PREDIV_TOP = 3'(PREDIV_RATIO - 1);
  localparam int DIV_W = 16;
  localparam logic [15:0] CD_OFF = 16'h0000;
  localparam logic [15:0] CD_BYPASS = 16'h0001;
  localparam logic [15:0] CD_RESET = 16'h0000;
  localparam logic [2:0] FP_RESET = 3'h0;
  // ==========================================================
  // oversampling and spi master clock limit
  localparam int OS_HIGH = 16;
  localparam int OS_LOW = 8;
  localparam logic [3:0] OS_TOP_16 = 4'(OS_HIGH - 1);
  localparam logic [3:0] OS_TOP_8 = 4'(OS_LOW - 1);
  localparam int SPI_MIN_PERIOD = 6;
  localparam logic [2:0] SPI_GAP_TOP = 3'(SPI_MIN_PERIOD - 1);
  localparam int CYC_W = 20;
  // ==========================================================
  // frame format
  localparam int WORD_W = 9;
  localparam logic [3:0] DLEN_MIN = 4'h5;
  localparam logic [3:0] DLEN_MAX = 4'h9;
  localparam logic [3:0] DLEN_RESET = 4'h8;
  localparam logic [1:0] STOP_1 = 2'h0;
  localparam logic [1:0] STOP_1P5 = 2'h1;
  localparam logic [1:0] STOP_2 = 2'h2;
  typedef enum logic [2:0] {
    PAR_EVEN = 3'h0,
    PAR_ODD = 3'h1,
    PAR_SPACE = 3'h2,
    PAR_MARK = 3'h3,
    PAR_NONE = 3'h4
  } usbc_parity_t;
  typedef enum logic [4:0] {
    FR_IDLE = 5'h01,
    FR_START = 5'h02,
    FR_DATA = 5'h04,
    FR_PARITY = 5'h08,
    FR_STOP = 5'h10
  } usbc_frame_t;
  // ==========================================================
  // transmit buffer
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
endpackage

// ===== rtl/usbc_pin_sync.sv
/*
  Three-stage synchroniser for one pin input.
  Assumes the input is asynchronous to sys_clk; the output changes only once
  the second and third stages agree.
*/
`timescale 1ns/1ps
module usbc_pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pin_in,
  output logic pin_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      pin_q <= RESET_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        pin_q <= s3_q;
      end
    end
  end
endmodule

// ===== rtl/usbc_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; in_ready and out_valid come from flip-flops.
*/
`timescale 1ns/1ps
module usbc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  wire push = in_valid && in_ready;
  wire pop = out_ready && out_valid;

  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_ptr_q];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      cnt_q <= cnt_d;
      in_ready <= cnt_d != (AW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end
endmodule

// ===== rtl/usbc_top.sv
/*
  Serial port bit clock generator, pin roles and frame engine (transmit and receive).
  Assumes configuration arrives as plain ports latched by cfg_write, pins are
  asynchronous and pass synchronisers, and periph_clock_on stands for the gated
  peripheral clock: while low, all serial state holds.
*/
// Function
// - one bit clock feeds transmitter and receiver
// - source: main clock, divided by eight, pin
// - sixteen-bit divider set by clock divisor
// - divisor zero stops the bit clock, except an external source in sync/spi
// - divisor one passes source clock through
// - clear-to-send low; slave select in slave
// - request-to-send low; slave select as master
// - spi master/slave swap data pin roles
// - stopped clock resumes from held state
// - configuration accepted while clock is stopped
// - five to nine bits, either bit order
// - stop bits 1, 1.5, 2 async; sync 1/2
// - parity even, odd, mark, space, none
// - receiver oversamples by eight or sixteen
// - spi master clock at most main/6
// - async: divided clock split by 16 or 8
// - fractional divisor adds eighths, async only
// - sync/spi bit clock is source over divisor
// - sync/spi external source used directly, undivided
`timescale 1ns/1ps
module usbc_top (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic periph_clock_on,
  input wire logic cfg_write,
  input wire logic [1:0] cfg_clock_source_select,
  input wire logic [usbc_pkg::DIV_W-1:0] cfg_clock_divisor,
  input wire logic [2:0] cfg_fractional_divisor,
  input wire logic cfg_sync_mode,
  input wire logic cfg_spi_mode,
  input wire logic cfg_spi_master,
  input wire logic cfg_oversample_by_eight,
  input wire logic cfg_handshake,
  input wire logic [3:0] cfg_data_length,
  input wire logic cfg_msb_first,
  input wire usbc_pkg::usbc_parity_t cfg_parity,
  input wire logic [1:0] cfg_stop_bits,
  input wire logic [usbc_pkg::WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [usbc_pkg::WORD_W-1:0] rx_data,
  output logic rx_valid,
  output logic rx_parity_err,
  output logic rx_frame_err,
  output logic bit_clock_tick,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  output logic txd_out,
  output logic txd_oe_n,
  input wire logic rxd_in,
  input wire logic cts_n_in,
  output logic rts_n_out
);
  import usbc_pkg::*;

  // ==========================================================
  // configuration
  logic [1:0] src_q;
  logic [DIV_W-1:0] cd_q;
  logic [2:0] fp_q;
  logic sync_q;
  logic spi_q;
  logic spi_master_q;
  logic over8_q;
  logic hs_q;
  logic [3:0] len_q;
  logic msb_q;
  usbc_parity_t par_q;
  logic [1:0] stop_q;
  wire [3:0] len_d = (cfg_data_length < DLEN_MIN) ? DLEN_MIN :
                     (cfg_data_length > DLEN_MAX) ? DLEN_MAX : cfg_data_length;

  // writes land whether or not the serial clock runs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_q <= CLK_SRC_RESET;
      cd_q <= CD_RESET;
      fp_q <= FP_RESET;
      sync_q <= 1'b0;
      spi_q <= 1'b0;
      spi_master_q <= 1'b0;
      over8_q <= 1'b0;
      hs_q <= 1'b0;
      len_q <= DLEN_RESET;
      msb_q <= 1'b0;
      par_q <= PAR_NONE;
      stop_q <= STOP_1;
    end else if (cfg_write) begin
      src_q <= cfg_clock_source_select;
      cd_q <= cfg_clock_divisor;
      fp_q <= cfg_fractional_divisor;
      sync_q <= cfg_sync_mode;
      spi_q <= cfg_spi_mode;
      spi_master_q <= cfg_spi_master;
      over8_q <= cfg_oversample_by_eight;
      hs_q <= cfg_handshake;
      len_q <= len_d;
      msb_q <= cfg_msb_first;
      par_q <= cfg_parity;
      stop_q <= cfg_stop_bits;
    end
  end

  wire run = periph_clock_on;
  wire async_md = !sync_q && !spi_q;
  wire spi_m = spi_q && spi_master_q;
  wire spi_s = spi_q && !spi_master_q;

  // ==========================================================
  // pin synchronisers
  logic sck_s;
  logic rxd_s;
  logic cts_n_s;
  usbc_pin_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .sys_clk(sys_clk), .reset_n(reset_n), .pin_in(sck_in), .pin_q(sck_s));
  usbc_pin_sync #(.RESET_VAL(1'b1)) u_sync_rxd (
    .sys_clk(sys_clk), .reset_n(reset_n), .pin_in(rxd_in), .pin_q(rxd_s));
  usbc_pin_sync #(.RESET_VAL(1'b1)) u_sync_cts (
    .sys_clk(sys_clk), .reset_n(reset_n), .pin_in(cts_n_in), .pin_q(cts_n_s));

  // ==========================================================
  // source selection and divider
  logic [2:0] prediv_q;
  logic sck_prev_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic [2:0] frac_acc_q;
  logic stretch_q;
  logic [3:0] os_cnt_q;
  logic [2:0] gap_q;
  logic pend_q;

  // external clock is only seen on rising edges; the far end keeps each phase
  // longer than one system period and the rate well below it
  wire sck_rise = sck_s && !sck_prev_q;
  wire prediv_tick = prediv_q == PREDIV_TOP;
  wire src_tick = run && ((src_q == CLK_SRC_EXT) ? sck_rise :
                          (src_q == CLK_SRC_DIV) ? prediv_tick : 1'b1);
  wire [2:0] frac_eff = (async_md && fp_q != FP_RESET) ? fp_q : 3'h0;
  wire [3:0] frac_sum = {1'b0, frac_acc_q} + {1'b0, frac_eff};
  wire [DIV_W-1:0] div_top = cd_q - CD_BYPASS + {{(DIV_W-1){1'b0}}, stretch_q};
  wire div_tick = (cd_q == CD_OFF) ? 1'b0 :
                  (cd_q == CD_BYPASS) ? src_tick :
                  src_tick && (div_cnt_q == div_top);
  wire [3:0] os_top = over8_q ? OS_TOP_8 : OS_TOP_16;
  wire async_bit = async_md && div_tick && (os_cnt_q == os_top);
  wire raw_sync = (src_q == CLK_SRC_EXT) ? src_tick : div_tick;
  wire gap_ok = !spi_m || (gap_q == SPI_GAP_TOP);
  wire bit_tick = async_md ? async_bit : (run && (raw_sync || pend_q) && gap_ok);
  // transmitter and receiver both step on this one tick stream
  wire unit_tick = async_md ? div_tick : bit_tick;
  wire [4:0] u_top = async_md ? {1'b0, os_top} : 5'h00;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prediv_q <= 3'h0;
      sck_prev_q <= 1'b0;
    end else if (run) begin
      prediv_q <= prediv_q + 3'h1;
      sck_prev_q <= sck_s;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= '0;
      frac_acc_q <= 3'h0;
      stretch_q <= 1'b0;
      os_cnt_q <= 4'h0;
    end else begin
      if (src_tick && cd_q > CD_BYPASS) begin
        div_cnt_q <= (div_cnt_q == div_top) ? '0 : div_cnt_q + CD_BYPASS;
      end
      if (div_tick) begin
        frac_acc_q <= frac_sum[2:0];
        stretch_q <= frac_sum[3];
        os_cnt_q <= (os_cnt_q == os_top) ? 4'h0 : os_cnt_q + 4'h1;
      end
    end
  end

  // a master tick arriving too early waits in pend_q instead of being lost
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= SPI_GAP_TOP;
      pend_q <= 1'b0;
    end else if (bit_tick) begin
      gap_q <= 3'h0;
      pend_q <= 1'b0;
    end else if (run) begin
      if (gap_q != SPI_GAP_TOP) begin
        gap_q <= gap_q + 3'h1;
      end
      if (raw_sync && !async_md) begin
        pend_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // serial clock output: low at each bit tick, high half a period later
  logic [CYC_W-1:0] cyc_q;
  logic [CYC_W-1:0] half_q;
  wire sck_master = !async_md && !spi_s && (src_q != CLK_SRC_EXT);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_q <= '0;
      half_q <= '0;
      sck_out <= 1'b0;
      sck_oe_n <= 1'b1;
      bit_clock_tick <= 1'b0;
    end else begin
      bit_clock_tick <= bit_tick;
      sck_oe_n <= !sck_master;
      if (bit_tick) begin
        half_q <= cyc_q >> 1;
        cyc_q <= '0;
        sck_out <= 1'b0;
      end else if (run) begin
        if (cyc_q != {CYC_W{1'b1}}) begin
          cyc_q <= cyc_q + {{(CYC_W-1){1'b0}}, 1'b1};
        end
        if (cyc_q == half_q) begin
          sck_out <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // frame helpers
  wire [WORD_W-1:0] len_mask = ~({WORD_W{1'b1}} << len_q);
  wire [4:0] stop_top = (stop_q == STOP_2) ? {u_top[3:0], 1'b1} :
                        (stop_q == STOP_1P5 && async_md) ? u_top + ((u_top + 5'h01) >> 1) :
                        u_top;

  function automatic logic par_of(input usbc_parity_t m, input logic [WORD_W-1:0] w,
                                  input logic [WORD_W-1:0] mask);
    logic x;
    x = ^(w & mask);
    case (m)
      PAR_EVEN: par_of = x;
      PAR_ODD: par_of = !x;
      PAR_MARK: par_of = 1'b1;
      default: par_of = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // transmit buffer and transmitter
  usbc_frame_t tx_state_q;
  logic [WORD_W-1:0] tx_word_q;
  logic [3:0] tx_idx_q;
  logic [4:0] tx_u_q;
  logic [WORD_W-1:0] fifo_data;
  logic fifo_valid;

  // in slave mode the select line gates shifting; as master cts is ignored, else handshake is optional
  wire tx_allow = spi_m ? 1'b1 : (spi_s || hs_q) ? !cts_n_s : 1'b1;
  wire fifo_pop = run && (tx_state_q == FR_IDLE) && fifo_valid && tx_allow;
  wire [4:0] tx_top = (tx_state_q == FR_STOP) ? stop_top : u_top;
  wire tx_end = unit_tick && (tx_u_q == tx_top);
  wire tx_last = tx_idx_q == (len_q - 4'h1);
  wire [3:0] tx_pos = msb_q ? (len_q - 4'h1 - tx_idx_q) : tx_idx_q;
  wire tx_par = par_of(par_q, tx_word_q, len_mask);
  wire txd_d = (tx_state_q == FR_START) ? 1'b0 :
               (tx_state_q == FR_DATA) ? tx_word_q[tx_pos] :
               (tx_state_q == FR_PARITY) ? tx_par : 1'b1;

  usbc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_q <= FR_IDLE;
      tx_word_q <= '0;
      tx_idx_q <= 4'h0;
      tx_u_q <= 5'h00;
    end else begin
      if (unit_tick && tx_state_q != FR_IDLE) begin
        tx_u_q <= tx_end ? 5'h00 : tx_u_q + 5'h01;
      end
      case (tx_state_q)
        FR_IDLE: if (fifo_pop) begin
          tx_word_q <= fifo_data;
          tx_idx_q <= 4'h0;
          tx_u_q <= 5'h00;
          tx_state_q <= spi_q ? FR_DATA : FR_START;
        end
        FR_START: if (tx_end) begin
          tx_state_q <= FR_DATA;
        end
        FR_DATA: if (tx_end) begin
          tx_idx_q <= tx_idx_q + 4'h1;
          if (tx_last) begin
            tx_state_q <= spi_q ? FR_IDLE : (par_q == PAR_NONE) ? FR_STOP : FR_PARITY;
          end
        end
        FR_PARITY: if (tx_end) begin
          tx_state_q <= FR_STOP;
        end
        FR_STOP: if (tx_end) begin
          tx_state_q <= FR_IDLE;
        end
        default: tx_state_q <= FR_IDLE;
      endcase
    end
  end

  // the data pin is mosi as master and miso as slave; a deselected slave lets go
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txd_out <= 1'b1;
      txd_oe_n <= 1'b0;
      rts_n_out <= 1'b1;
    end else begin
      txd_out <= txd_d;
      txd_oe_n <= spi_s ? cts_n_s : 1'b0;
      rts_n_out <= spi_m ? (tx_state_q == FR_IDLE) : !run;
    end
  end

  // ==========================================================
  // receiver
  usbc_frame_t rx_state_q;
  logic [WORD_W-1:0] rx_word_q;
  logic [3:0] rx_idx_q;
  logic [4:0] rx_u_q;
  logic rx_perr_q;

  wire rx_end = unit_tick && (rx_u_q == u_top);
  wire rx_last = rx_idx_q == (len_q - 4'h1);
  // receive pin is miso as master, mosi as slave
  wire [3:0] rx_pos = msb_q ? (len_q - 4'h1 - rx_idx_q) : rx_idx_q;
  wire spi_go = spi_m ? (tx_state_q == FR_DATA) : !cts_n_s;
  wire rx_go = spi_q ? spi_go : (!rxd_s && (async_md || unit_tick));
  // in async mode the start bit is confirmed at its middle
  wire [4:0] rx_half = u_top >> 1;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_q <= FR_IDLE;
      rx_word_q <= '0;
      rx_idx_q <= 4'h0;
      rx_u_q <= 5'h00;
      rx_perr_q <= 1'b0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (unit_tick && rx_state_q != FR_IDLE && rx_state_q != FR_START) begin
        rx_u_q <= rx_end ? 5'h00 : rx_u_q + 5'h01;
      end
      case (rx_state_q)
        FR_IDLE: if (run && rx_go) begin
          rx_word_q <= '0;
          rx_idx_q <= 4'h0;
          rx_u_q <= 5'h00;
          rx_perr_q <= 1'b0;
          rx_state_q <= async_md ? FR_START : FR_DATA;
        end
        FR_START: if (unit_tick) begin
          if (rx_u_q == rx_half) begin
            rx_u_q <= 5'h00;
            rx_state_q <= rxd_s ? FR_IDLE : FR_DATA;
          end else begin
            rx_u_q <= rx_u_q + 5'h01;
          end
        end
        FR_DATA: if (rx_end) begin
          rx_word_q[rx_pos] <= rxd_s;
          rx_idx_q <= rx_idx_q + 4'h1;
          if (rx_last) begin
            rx_state_q <= (spi_q || par_q == PAR_NONE) ? FR_STOP : FR_PARITY;
          end
        end
        FR_PARITY: if (rx_end) begin
          rx_perr_q <= rxd_s != par_of(par_q, rx_word_q, len_mask);
          rx_state_q <= FR_STOP;
        end
        FR_STOP: if (run && (spi_q || rx_end)) begin
          rx_data <= rx_word_q;
          rx_valid <= 1'b1;
          rx_parity_err <= rx_perr_q;
          rx_frame_err <= !spi_q && !rxd_s;
          rx_state_q <= FR_IDLE;
        end
        default: rx_state_q <= FR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checks
  logic [3:0] chk_os_q;
  logic chk_ok_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_os_q <= 4'h0;
      chk_ok_q <= 1'b0;
    end else if (cfg_write) begin
      chk_ok_q <= 1'b0;
    end else if (bit_tick && async_md) begin
      chk_os_q <= 4'h0;
      chk_ok_q <= 1'b1;
    end else if (div_tick) begin
      chk_os_q <= chk_os_q + 4'h1;
    end
  end

  a_cd_zero_silent: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cd_q == CD_OFF && !pend_q && src_q != CLK_SRC_EXT |-> !div_tick && !bit_tick ##1 !bit_clock_tick)
    else $error("bit clock ticked with divisor zero");

  a_cd_one_bypass: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cd_q == CD_BYPASS && src_tick |-> div_tick)
    else $error("divisor one did not pass the source clock");

  a_stop_holds_state: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !periph_clock_on |=> $stable(tx_state_q) && $stable(rx_state_q) && $stable(div_cnt_q))
    else $error("state moved while the peripheral clock was off");

  a_cfg_while_off: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cfg_write && !periph_clock_on |=> cd_q == $past(cfg_clock_divisor) && src_q == $past(cfg_clock_source_select))
    else $error("configuration lost while the clock was off");

  a_spi_master_gap: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    spi_m && !async_md && bit_tick |=> !bit_tick [*5])
    else $error("spi master bit clock faster than one sixth");

  a_ext_direct_sync: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    sync_q && !spi_q && src_q == CLK_SRC_EXT && src_tick |-> bit_tick ##1 bit_clock_tick)
    else $error("external clock not used directly in sync mode");

  a_rts_slave_sel: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    spi_m && tx_state_q == FR_DATA && $past(tx_state_q) == FR_DATA |-> !rts_n_out)
    else $error("slave select not low during master frame");

  a_async_os_ratio: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    async_md && bit_tick && chk_ok_q && !cfg_write |-> chk_os_q == os_top)
    else $error("async bit clock not sixteen or eight sample ticks");
endmodule

// ===== tb/usbc_peer.sv
/*
  Remote serial terminal model: samples frames on txd, sends frames on rxd.
  Assumes async timing of bit_cyc system clocks per bit on one clock.
*/
`timescale 1ns/1ps
module usbc_peer (
  input wire logic sys_clk,
  input wire logic txd,
  input wire logic stall,
  input wire logic [7:0] bit_cyc,
  input wire logic [3:0] nsamp,
  output logic rxd,
  output logic cts_n
);
  logic [11:0] got = '0;
  int frames = 0;
  // ==========================================
  // receive side, sampled mid-bit
  assign cts_n = stall;
  initial begin
    forever begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge sys_clk);
      for (int i = 0; i < nsamp; i++) begin
        repeat (bit_cyc) @(posedge sys_clk);
        got[i] = txd;
      end
      frames++;
    end
  end
  // ==========================================
  // send side; idle line rests at mark level
  initial rxd = 1'b1;
  task automatic send(input logic [12:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      rxd = b[i];
      repeat (bit_cyc - 1) @(negedge sys_clk);
    end
  endtask
endmodule

// ===== tb/usbc_top_tb.sv
/*
  Self-checking bench for usbc_top: bit clock periods, frames both ways, buffer.
  Assumes the peer model in usbc_peer.sv and a 40 MHz sys_clk.
*/
`timescale 1ns/1ps
module usbc_top_tb;
  import usbc_pkg::*;
  logic sys_clk, reset_n = 1'b0, periph_clock_on = 1'b0, cfg_write = 1'b0, sync = 1'b0, ov8 = 1'b0;
  logic hs = 1'b0, msb = 1'b0, tx_valid = 1'b0, stall = 1'b0, rx_perr, tx_ready, tick, txd_out, txd_oe_n;
  logic sck = 1'b0, sck_on = 1'b0, spi = 1'b0, sck_oe_n;
  logic [1:0] src = '0;
  logic [15:0] cd = '0;
  logic [2:0] fp = '0;
  logic [3:0] len = 4'h8, nsamp = 4'h0;
  logic [7:0] bit_cyc = 8'h08;
  logic [8:0] tx_data = '0, rx_data, rx_word;
  usbc_parity_t par = PAR_NONE;
  logic rx_valid, rx_parity_err, rx_frame_err, rxd, cts_n, rts_n_out;
  int n_fail = 0, checks = 0, rx_n = 0;
  usbc_top usbc_top_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .periph_clock_on(periph_clock_on), .cfg_write(cfg_write),
    .cfg_clock_source_select(src), .cfg_clock_divisor(cd), .cfg_fractional_divisor(fp),
    .cfg_sync_mode(sync), .cfg_spi_mode(spi), .cfg_spi_master(spi), .cfg_oversample_by_eight(ov8),
    .cfg_handshake(hs), .cfg_data_length(len), .cfg_msb_first(msb), .cfg_parity(par),
    .cfg_stop_bits(STOP_1), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err),
    .bit_clock_tick(tick), .sck_in(sck), .sck_out(), .sck_oe_n(sck_oe_n), .txd_out(txd_out),
    .txd_oe_n(txd_oe_n), .rxd_in(rxd), .cts_n_in(cts_n), .rts_n_out(rts_n_out));
  usbc_peer usbc_peer_i (.sys_clk(sys_clk), .txd(txd_out), .stall(stall), .bit_cyc(bit_cyc),
    .nsamp(nsamp), .rxd(rxd), .cts_n(cts_n));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // external serial clock: two system cycles per phase, held low when off
  always begin
    repeat (2) @(negedge sys_clk);
    sck = sck_on & ~sck;
  end
  always @(negedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      rx_word = rx_data;
      rx_perr = rx_parity_err;
      rx_n++;
    end
  end
  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic setup(input logic [1:0] s, input logic [15:0] d, input logic [2:0] f, input logic o8);
    @(negedge sys_clk);
    src = s;
    cd = d;
    fp = f;
    ov8 = o8;
    cfg_write = 1'b1;
    @(negedge sys_clk);
    cfg_write = 1'b0;
  endtask
  // period in unfrozen cycles; a freeze mid-period must not shift the next tick
  task automatic period(input int exp, input bit frz);
    int n;
    n = 0;
    // skip a tick that may still come from the previous setting
    @(negedge sys_clk);
    while (tick !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (frz && n == 5) begin
        periph_clock_on = 1'b0;
        repeat (40) @(negedge sys_clk);
        chk("frozen tick", tick, 0);
        periph_clock_on = 1'b1;
      end
    end while (tick !== 1'b1 && n < 3000);
    chk("tick period", n, exp);
  endtask
  task automatic build(input logic [8:0] d, output logic [11:0] b);
    int k;
    b = '0;
    for (k = 0; k < len; k++) b[k] = msb ? d[len-1-k] : d[k];
    if (par == PAR_MARK) b[k] = 1'b1;
    else if (par != PAR_SPACE) b[k] = (par == PAR_ODD) ^ (^(d & ~(9'h1ff << len)));
    if (par != PAR_NONE) k++;
    b[k] = 1'b1;
    nsamp = 4'(k + 1);
  endtask
  task automatic wait_frames(input int t);
    int g;
    g = 0;
    while (usbc_peer_i.frames < t && g < 8000) begin
      @(negedge sys_clk);
      g++;
    end
  endtask
  // ==========================================
  // scenarios
  task automatic trip(input logic [8:0] d, input logic bad);
    logic [11:0] b;
    int f;
    build(d, b);
    f = usbc_peer_i.frames;
    tx_data = d;
    tx_valid = 1'b1;
    @(negedge sys_clk);
    tx_valid = 1'b0;
    wait_frames(f + 1);
    chk("txd frame", usbc_peer_i.got & ((12'h001 << nsamp) - 1), b);
    f = rx_n;
    b[nsamp-2] ^= bad;
    usbc_peer_i.send({b, 1'b0}, nsamp + 1);
    repeat (16) @(negedge sys_clk);
    chk("rx count", rx_n, f + 1);
    chk("rx data", rx_word & ~(9'h1ff << len), d & ~(9'h1ff << len));
    chk("rx parity err", rx_perr, bad);
    chk("rx frame err", rx_frame_err, 0);
  endtask
  task automatic fill();
    logic [11:0] b;
    int n, f;
    n = 0;
    hs = 1'b1;
    // cts must read high before the clock runs, or one word slips out
    stall = 1'b1;
    par = PAR_NONE;
    len = 4'h8;
    bit_cyc = 8'h08;
    build(9'h0f0, b);
    periph_clock_on = 1'b0;
    setup(CLK_SRC_MAIN, 16'h0001, 3'h0, 1'b1);
    chk("rts off", rts_n_out, 1);
    tx_valid = 1'b1;
    repeat (40) begin
      if (tx_ready === 1'b1) n++;
      @(negedge sys_clk);
    end
    tx_valid = 1'b0;
    chk("fifo words", n, FIFO_DEPTH);
    periph_clock_on = 1'b1;
    f = usbc_peer_i.frames;
    repeat (100) @(negedge sys_clk);
    chk("rts on", rts_n_out, 0);
    chk("held by cts", usbc_peer_i.frames, f);
    stall = 1'b0;
    wait_frames(f + FIFO_DEPTH);
    chk("drained", usbc_peer_i.frames - f, FIFO_DEPTH);
    chk("ready again", tx_ready, 1);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    int n;
    n = 0;
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    chk("txd idle", txd_out, 1);
    chk("txd driven", txd_oe_n, 0);
    chk("tx ready", tx_ready, 1);
    setup(CLK_SRC_MAIN, CD_OFF, 3'h0, 1'b1);
    periph_clock_on = 1'b1;
    repeat (300) begin
      @(negedge sys_clk);
      if (tick === 1'b1) n++;
    end
    chk("no tick", n, 0);
    periph_clock_on = 1'b0;
    setup(CLK_SRC_MAIN, CD_BYPASS, 3'h0, 1'b1);
    periph_clock_on = 1'b1;
    period(OS_LOW, 0);
    setup(CLK_SRC_MAIN, 16'h0003, 3'h0, 1'b0);
    period(3 * OS_HIGH, 1);
    setup(CLK_SRC_DIV, 16'h0001, 3'h0, 1'b1);
    period(PREDIV_RATIO * OS_LOW, 0);
    setup(CLK_SRC_MAIN, 16'h0003, 3'h4, 1'b0);
    period(56, 0);
    sync = 1'b1;
    setup(CLK_SRC_MAIN, 16'h0005, 3'h0, 1'b0);
    period(5, 0);
    sck_on = 1'b1;
    setup(CLK_SRC_EXT, 16'h0005, 3'h0, 1'b0);
    period(4, 0);
    chk("sck input", sck_oe_n, 1);
    sck_on = 1'b0;
    spi = 1'b1;
    setup(CLK_SRC_MAIN, 16'h0001, 3'h0, 1'b0);
    period(SPI_MIN_PERIOD, 0);
    chk("sck driven", sck_oe_n, 0);
    spi = 1'b0;
    sync = 1'b0;
    for (int i = 0; i < 5; i++) begin
      par = usbc_parity_t'(i);
      len = 4'(5 + i);
      msb = i[0];
      bit_cyc = i[0] ? 8'h10 : 8'h08;
      setup(CLK_SRC_MAIN, 16'h0001, 3'h0, ~i[0]);
      trip(9'h1a5, 1'b0);
    end
    par = PAR_EVEN;
    setup(CLK_SRC_MAIN, 16'h0001, 3'h0, 1'b1);
    trip(9'h03c, 1'b1);
    fill();
    conclude();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule
